// *** core/sacc_pkg.sv ***
// Purpose: Shared constants for the SMM space access control block
// Assumes: 8-bit configuration port, host address bits 31:3 on the host bus
// Notes: Segment A0000h-BFFFFh is 128 Kbytes, so it is matched on address bits 31:17
package sacc_pkg;
  // Register offset in configuration space
  localparam logic [7:0] SMM_SPACE_CONTROL_OFS = 8'h72;
  // Value after reset: base segment 010, everything else clear
  localparam logic [7:0] SMM_SPACE_CONTROL_RST = 8'h02;
  // Field positions
  localparam int OPEN_BIT = 6;
  localparam int CLOSED_BIT = 5;
  localparam int LOCK_BIT = 4;
  localparam int ENABLE_BIT = 3;
  localparam int BASE_LSB = 0;
  localparam int BASE_W = 3;
  // Only legal base code and the segment it selects (address bits 31:17)
  localparam logic [2:0] BASE_SEG_A = 3'h2;
  localparam logic [14:0] SEG_A_TAG = 15'h0005;
  // Where a host cycle goes
  typedef enum logic [1:0] {
    SACC_TO_PCI = 2'b00,
    SACC_TO_DRAM = 2'b01,
    SACC_TO_INVALID = 2'b10
  } sacc_target_t;
endpackage : sacc_pkg

// *** core/sacc_route.sv ***
// Purpose: Routing decision for one cycle that hits the SMM segment
// Assumes: Control bits come straight from the control register
// Notes: Pure combinational table; the caller registers the result
`timescale 1ns/1ns
module sacc_route (
  // Control bits
  input wire logic enable,
  input wire logic lock,
  input wire logic closed,
  input wire logic open,
  // Cycle attributes
  input wire logic mode_active,
  input wire logic code_fetch,
  // Decision
  output sacc_pkg::sacc_target_t target
);
  // Priority follows the decode table from the top row down
  always_comb begin
    if (!enable) begin
      target = sacc_pkg::SACC_TO_PCI;
    end else if (open && closed && !lock) begin
      target = sacc_pkg::SACC_TO_INVALID; // Software must never program this
    end else if (open && !lock) begin
      target = sacc_pkg::SACC_TO_DRAM;
    end else if (!mode_active) begin
      target = sacc_pkg::SACC_TO_PCI;
    end else if (closed && !code_fetch) begin
      target = sacc_pkg::SACC_TO_PCI;
    end else begin
      target = sacc_pkg::SACC_TO_DRAM;
    end
  end
endmodule : sacc_route

// *** core/sacc_smm_ctrl.sv ***
// Purpose: SMM space control register and host/PCI cycle routing for segment A
// Assumes: Host bus signals and config port are synchronous to CLK; RSTN is power-on reset
// Notes: Route outputs stand one cycle after the address strobe, for one cycle
`timescale 1ns/1ns
// Notes on behaviour
// - Open, closed and lock act only with enable set; else segment goes PCI.
// - Open set, closed and lock clear route segment to DRAM without mode-active.
// - Closed and mode-active, open clear or locked: data goes to PCI, code fetches go to DRAM.
// - Writing lock forces open to 0; lock and open become read-only.
// - Lock set by normal write; only power-on reset clears it.
// - Enable exposes 128 Kbytes DRAM at A0000h to strobes with mode-active.
// - No remapping; cycles not permitted to DRAM go to PCI, except with open and closed set and lock clear, which route invalid.
// - Routing follows the decode table for every combination.
module sacc_smm_ctrl (
  // Clock and power-on reset
  input wire logic CLK,
  input wire logic RSTN,
  // Configuration port
  input wire logic CFG_WR,
  input wire logic CFG_RD,
  input wire logic [7:0] CFG_ADDR,
  input wire logic [7:0] CFG_WDATA,
  output logic [7:0] CFG_RDATA,
  // Host cycle
  input wire logic HOST_ADDR_STROBE_N,
  input wire logic [31:3] HOST_ADDR,
  input wire logic HOST_CODE_FETCH,
  input wire logic SYSMGMT_ACTIVE_N,
  // Host routing result
  output logic ROUTE_VALID,
  output logic ROUTE_DRAM,
  output logic ROUTE_PCI,
  output logic ROUTE_INVALID,
  // PCI initiator cycle check
  input wire logic PCI_REQ,
  input wire logic [31:3] PCI_ADDR,
  output logic PCI_SMM_BLOCK,
  // Control state for the DRAM path
  output logic SMM_REGION_ENABLE
);
  logic smm_open;
  logic smm_closed;
  logic smm_lock;
  logic smm_region_enable;
  logic [2:0] smm_base_segment;
  logic [7:0] reg_view;
  logic reg_sel;
  logic host_hit;
  logic pci_hit;
  logic next_open;
  sacc_pkg::sacc_target_t target;

  assign reg_sel = CFG_ADDR == sacc_pkg::SMM_SPACE_CONTROL_OFS;
  // A reserved base code disables the segment decode altogether
  assign host_hit = !HOST_ADDR_STROBE_N && smm_base_segment == sacc_pkg::BASE_SEG_A
                    && HOST_ADDR[31:17] == sacc_pkg::SEG_A_TAG;
  assign pci_hit = PCI_REQ && smm_base_segment == sacc_pkg::BASE_SEG_A
                   && PCI_ADDR[31:17] == sacc_pkg::SEG_A_TAG;
  // Register view with reserved bit 7 tied low
  assign reg_view = {1'b0, smm_open, smm_closed, smm_lock, smm_region_enable,
                     smm_base_segment};

  // Open follows writes only while unlocked; a lock write clears it in the same edge
  always_comb begin
    next_open = smm_open;
    if (smm_lock) begin
      next_open = 1'b0;
    end else if (CFG_WR && reg_sel) begin
      next_open = CFG_WDATA[sacc_pkg::OPEN_BIT] && !CFG_WDATA[sacc_pkg::LOCK_BIT];
    end
  end

  // Lock and open: only reset can clear lock, so a locked region stays locked
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      smm_lock <= 1'b0;
      smm_open <= 1'b0;
    end else begin
      smm_open <= next_open;
      if (CFG_WR && reg_sel && CFG_WDATA[sacc_pkg::LOCK_BIT]) begin
        smm_lock <= 1'b1;
      end
    end
  end

  // Freely writable fields; bit 7 is dropped on the floor
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      smm_closed <= sacc_pkg::SMM_SPACE_CONTROL_RST[sacc_pkg::CLOSED_BIT];
      smm_region_enable <= sacc_pkg::SMM_SPACE_CONTROL_RST[sacc_pkg::ENABLE_BIT];
      smm_base_segment <= sacc_pkg::SMM_SPACE_CONTROL_RST[2:0];
    end else if (CFG_WR && reg_sel) begin
      smm_closed <= CFG_WDATA[sacc_pkg::CLOSED_BIT];
      smm_region_enable <= CFG_WDATA[sacc_pkg::ENABLE_BIT];
      smm_base_segment <= CFG_WDATA[2:0];
    end
  end

  // Read data is captured the cycle after the read; other offsets read zero
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      CFG_RDATA <= 8'h00;
    end else if (CFG_RD && reg_sel) begin
      CFG_RDATA <= reg_view;
    end else begin
      CFG_RDATA <= 8'h00;
    end
  end

  // Routing table for the current cycle
  sacc_route u_route (
    .enable(smm_region_enable),
    .lock(smm_lock),
    .closed(smm_closed),
    .open(smm_open),
    .mode_active(!SYSMGMT_ACTIVE_N),
    .code_fetch(HOST_CODE_FETCH),
    .target(target)
  );

  // Host decision, one cycle after the strobe; misses are not ours to route
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      ROUTE_VALID <= 1'b0;
      ROUTE_DRAM <= 1'b0;
      ROUTE_PCI <= 1'b0;
      ROUTE_INVALID <= 1'b0;
    end else begin
      ROUTE_VALID <= host_hit;
      ROUTE_DRAM <= host_hit && target == sacc_pkg::SACC_TO_DRAM;
      ROUTE_PCI <= host_hit && target == sacc_pkg::SACC_TO_PCI;
      ROUTE_INVALID <= host_hit && target == sacc_pkg::SACC_TO_INVALID;
    end
  end

  // PCI initiators in the segment are kept off SMM DRAM while the region is enabled
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      PCI_SMM_BLOCK <= 1'b0;
      SMM_REGION_ENABLE <= 1'b0;
    end else begin
      PCI_SMM_BLOCK <= pci_hit && smm_region_enable;
      SMM_REGION_ENABLE <= smm_region_enable;
    end
  end

  a_disabled_pci: assert property (@(posedge CLK) disable iff (!RSTN)
    host_hit && !smm_region_enable |=> ROUTE_PCI && !ROUTE_DRAM)
    else $error("Disabled region routed away from PCI");

  a_open_unlocked: assert property (@(posedge CLK) disable iff (!RSTN)
    host_hit && smm_region_enable && smm_open && !smm_lock && !smm_closed
    |=> ROUTE_DRAM)
    else $error("Open region not routed to DRAM");

  a_closed_data: assert property (@(posedge CLK) disable iff (!RSTN)
    host_hit && smm_region_enable && smm_closed && !SYSMGMT_ACTIVE_N
    && (smm_lock || !smm_open)
    |=> (ROUTE_DRAM == $past(HOST_CODE_FETCH)) && (ROUTE_PCI == !$past(HOST_CODE_FETCH)))
    else $error("Closed region split of code and data wrong");

  a_lock_clears_open: assert property (@(posedge CLK) disable iff (!RSTN)
    CFG_WR && reg_sel && CFG_WDATA[sacc_pkg::LOCK_BIT] |=> smm_lock && !smm_open [*2])
    else $error("Lock write did not force open low");

  a_lock_sticky: assert property (@(posedge CLK) disable iff (!RSTN)
    smm_lock |=> smm_lock)
    else $error("Lock cleared without power-on reset");

  a_active_dram: assert property (@(posedge CLK) disable iff (!RSTN)
    host_hit && smm_region_enable && !SYSMGMT_ACTIVE_N && !smm_closed
    |=> ROUTE_DRAM && ROUTE_VALID)
    else $error("Mode-active access not given DRAM");

  a_inactive_pci: assert property (@(posedge CLK) disable iff (!RSTN)
    host_hit && smm_region_enable && SYSMGMT_ACTIVE_N && (smm_lock || !smm_open)
    |=> ROUTE_PCI)
    else $error("Inactive access not sent to PCI");

  a_one_target: assert property (@(posedge CLK) disable iff (!RSTN)
    ROUTE_VALID |-> $onehot({ROUTE_DRAM, ROUTE_PCI, ROUTE_INVALID}))
    else $error("Routed cycle lacks exactly one target");

  a_pci_blocked: assert property (@(posedge CLK) disable iff (!RSTN)
    pci_hit && smm_region_enable |=> PCI_SMM_BLOCK)
    else $error("PCI initiator not blocked from SMM space");

  a_reserved_zero: assert property (@(posedge CLK) disable iff (!RSTN)
    CFG_RD && reg_sel |=> !CFG_RDATA[7] && CFG_RDATA[2:0] == $past(smm_base_segment))
    else $error("Read data for control register wrong");

  // Open can never be seen set while the region is locked
  a_locked_open_low: assert property (@(posedge CLK) disable iff (!RSTN)
    smm_lock |-> !smm_open)
    else $error("Open bit set while locked");

  // A strobe outside the segment must leave every route output quiet
  a_miss_quiet: assert property (@(posedge CLK) disable iff (!RSTN)
    !host_hit |=> !ROUTE_VALID && !ROUTE_DRAM && !ROUTE_PCI && !ROUTE_INVALID)
    else $error("Route output without a segment hit");

  a_locked_active: assert property (@(posedge CLK) disable iff (!RSTN)
    host_hit && smm_region_enable && smm_lock && !smm_closed && !SYSMGMT_ACTIVE_N
    |=> ROUTE_DRAM && ROUTE_VALID)
    else $error("Locked mode-active access not given DRAM");

  a_pci_quiet: assert property (@(posedge CLK) disable iff (!RSTN)
    !pci_hit |=> !PCI_SMM_BLOCK)
    else $error("PCI block raised without a segment access");

  a_rdata_idle: assert property (@(posedge CLK) disable iff (!RSTN)
    !(CFG_RD && reg_sel) |=> CFG_RDATA == 8'h00)
    else $error("Read data not zero outside a register read");

  // No disable here: the point is to look at the state that reset leaves behind
  a_reset_state: assert property (@(posedge CLK)
    !RSTN |=> !smm_lock && !smm_open && !smm_closed && !smm_region_enable
    && smm_base_segment == sacc_pkg::SMM_SPACE_CONTROL_RST[2:0] && CFG_RDATA == 8'h00)
    else $error("Register state after reset wrong");
endmodule : sacc_smm_ctrl

// *** testbench/sacc_host_model.sv ***
// Purpose: Host processor and PCI initiator model for the SMM segment
// Assumes: Drives 1 ns after the rising edge of CLK
// Notes: Released address lines flip, so a stale value cannot pass for a hold
`timescale 1ns/1ns
module sacc_host_model (
  // Clock
  input wire logic clk,
  // Host cycle
  output logic host_addr_strobe_n,
  output logic [31:3] host_addr,
  output logic host_code_fetch,
  output logic sysmgmt_active_n,
  // PCI initiator
  output logic pci_req,
  output logic [31:3] pci_addr
);
  // Idle bus at time zero
  initial begin
    host_addr_strobe_n = 1'b1;
    host_addr = '0;
    host_code_fetch = 1'b0;
    sysmgmt_active_n = 1'b1;
    pci_req = 1'b0;
    pci_addr = '0;
  end
  // One cycle, held across exactly one sampling edge
  task automatic issue(input logic pci, input logic [31:0] a, input logic code,
                       input logic smi_n);
    @(posedge clk);
    #1;
    sysmgmt_active_n = smi_n;
    if (pci) begin
      pci_req = 1'b1;
      pci_addr = a[31:3];
    end else begin
      host_addr_strobe_n = 1'b0;
      host_addr = a[31:3];
      host_code_fetch = code;
    end
    @(posedge clk);
    #1;
    host_addr_strobe_n = 1'b1;
    pci_req = 1'b0;
    host_addr = ~host_addr;
    pci_addr = ~pci_addr;
  endtask : issue
endmodule : sacc_host_model

// *** testbench/sacc_smm_ctrl_test.sv ***
// Purpose: Self-checking bench for SMM segment control and routing
// Assumes: Inputs change 1 ns after the rising edge
// Notes: Route result packed as {block, valid, dram, pci, invalid}
`timescale 1ns/1ns
module sacc_smm_ctrl_test;
  logic clk;
  logic rstn;
  logic cfg_wr;
  logic cfg_rd;
  logic [7:0] cfg_addr;
  logic [7:0] cfg_wdata;
  logic [7:0] cfg_rdata;
  logic stb_n, code, smi_n, v, d, p, inv, preq, blk, en;
  logic [31:3] ha;
  logic [31:3] pa;
  int fails = 0;
  int check_count = 0;
  sacc_host_model sacc_host_model_i (.clk(clk), .host_addr_strobe_n(stb_n),
    .host_addr(ha), .host_code_fetch(code), .sysmgmt_active_n(smi_n),
    .pci_req(preq), .pci_addr(pa));
  sacc_smm_ctrl sacc_smm_ctrl_i (.CLK(clk), .RSTN(rstn), .CFG_WR(cfg_wr),
    .CFG_RD(cfg_rd), .CFG_ADDR(cfg_addr), .CFG_WDATA(cfg_wdata),
    .CFG_RDATA(cfg_rdata), .HOST_ADDR_STROBE_N(stb_n), .HOST_ADDR(ha),
    .HOST_CODE_FETCH(code), .SYSMGMT_ACTIVE_N(smi_n), .ROUTE_VALID(v),
    .ROUTE_DRAM(d), .ROUTE_PCI(p), .ROUTE_INVALID(inv), .PCI_REQ(preq),
    .PCI_ADDR(pa), .PCI_SMM_BLOCK(blk), .SMM_REGION_ENABLE(en));
  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic check(input string n, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", n, exp, seen);
    end
  endtask : check
  // Write strobe stands for one edge
  task automatic wr(input logic [7:0] data);
    cfg_wr = 1'b1;
    cfg_addr = sacc_pkg::SMM_SPACE_CONTROL_OFS;
    cfg_wdata = data;
    @(posedge clk);
    #1;
    cfg_wr = 1'b0;
  endtask : wr
  // Read data is looked at the cycle after the strobe
  task automatic rd(input logic [7:0] exp);
    cfg_rd = 1'b1;
    cfg_addr = sacc_pkg::SMM_SPACE_CONTROL_OFS;
    @(posedge clk);
    #1;
    cfg_rd = 1'b0;
    check("control", cfg_rdata, exp);
    check("enable", {7'h00, en}, {7'h00, exp[sacc_pkg::ENABLE_BIT]});
  endtask : rd
  task automatic rt(input logic pci, input logic [31:0] a, input logic c,
                    input logic s, input logic [7:0] exp);
    sacc_host_model_i.issue(pci, a, c, s);
    check("route", {3'h0, blk, v, d, p, inv}, exp);
  endtask : rt
  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : stop_test
  // Main sequence: open, closed, lock, then power-on reset
  initial begin
    rstn = 1'b0;
    cfg_wr = 1'b0;
    cfg_rd = 1'b0;
    cfg_addr = 8'h00;
    cfg_wdata = 8'h00;
    repeat (5) @(posedge clk);
    #1;
    rstn = 1'b1;
    rd(8'h02);
    rt(1'b0, 32'h000a0000, 1'b0, 1'b0, 8'h0a);
    wr(8'h4a);
    rt(1'b0, 32'h000a0000, 1'b0, 1'b1, 8'h0c);
    wr(8'h0a);
    rt(1'b0, 32'h000bfff8, 1'b0, 1'b1, 8'h0a);
    rt(1'b0, 32'h000a0000, 1'b0, 1'b0, 8'h0c);
    rt(1'b0, 32'h000c0000, 1'b0, 1'b0, 8'h00);
    rt(1'b1, 32'h000a0000, 1'b0, 1'b0, 8'h10);
    $display("test unlocked done");
    wr(8'h2a);
    rt(1'b0, 32'h000a0000, 1'b1, 1'b0, 8'h0c);
    rt(1'b0, 32'h000a0000, 1'b0, 1'b0, 8'h0a);
    wr(8'hda);
    rd(8'h1a);
    wr(8'h4a);
    rd(8'h1a);
    rt(1'b0, 32'h000a0000, 1'b0, 1'b1, 8'h0a);
    rt(1'b0, 32'h000a0000, 1'b0, 1'b0, 8'h0c);
    $display("test locked done");
    rstn = 1'b0;
    @(posedge clk);
    #1;
    rstn = 1'b1;
    rd(8'h02);
    $display("test reset done");
    stop_test();
  end
endmodule : sacc_smm_ctrl_test
